// file: design/input_cal_ctrl.sv
// register bank for lane pre-emphasis, input multiplexer and calibration enable
// assumes a simple synchronous register port and a calibration engine outside
`timescale 1ns/1ns
`include "input_cal_cfg.svh"
module input_cal_ctrl (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // register port
  input  wire input_cal_pkg::reg_req_t req,
  output logic [7:0]                  rdata,
  // mode from link format selection
  input  wire logic                   single_mode,
  // calibration engine handshake
  input  wire logic                   cal_done,
  // outputs to the analog and serializer side
  output input_cal_pkg::preemph_t     lane_preemph [`NUM_LANES],
  output input_cal_pkg::route_t       input_route,
  output logic                        solo_interleave,
  output logic                        cal_reset,
  output logic                        div_reset
);
  import input_cal_pkg::*;

  logic [7:0] pe_reg, pe_next;
  logic [7:0] sel_reg, sel_next;
  logic [7:0] cal_reg, cal_next;
  logic [7:0] rdata_reg, rdata_next;
  route_t     route_reg, route_next;
  logic       inter_reg, inter_next;
  logic       calr_reg, calr_next;
  logic       divr_reg, divr_next;
  preemph_t   pe_out_reg [`NUM_LANES];
  preemph_t   pe_out_next;

  // mux selection as software wrote it, translated to a route
  function automatic route_t decode_route(input logic [7:0] sel, input logic solo);
    if (!solo)
      decode_route = sel[`BIT_SWAP] ? ROUTE_B_A : ROUTE_A_B;
    else if (sel[1:0] == 2'h2)
      decode_route = ROUTE_SOLO_B;
    else if (sel[1:0] == 2'h3)
      decode_route = ROUTE_A_B;
    else
      decode_route = ROUTE_SOLO_A; // (reserved code falls to A)
  endfunction : decode_route

  // register writes and read data; reserved bits hold zero so reads show zero
  always_comb
  begin
    pe_next    = pe_reg;
    sel_next   = sel_reg;
    cal_next   = cal_reg;
    rdata_next = 8'h00;
    if (req.wr)
    begin
      case (req.addr)
        `OFS_LANE_PREEMPH_LEVEL:    pe_next  = req.wdata & `MASK_LANE_PREEMPH_LEVEL;
        `OFS_INPUT_SEL: sel_next = req.wdata & `MASK_INPUT_SEL;
        `OFS_CAL_EN:    cal_next = req.wdata & `MASK_CAL_EN;
        default:        ;
      endcase
    end
    if (req.rd)
    begin
      case (req.addr)
        `OFS_LANE_PREEMPH_LEVEL:    rdata_next = pe_reg;
        `OFS_INPUT_SEL: rdata_next = sel_reg;
        `OFS_CAL_EN:    rdata_next = cal_reg;
        default:        rdata_next = 8'h00;
      endcase
    end
  end

  // routing is latched only when a calibration completes, so a mux change
  // waits for the next calibration rather than glitching live samples
  always_comb
  begin
    route_next = route_reg;
    inter_next = inter_reg;
    if (cal_reg[`BIT_CAL_RUN] && cal_done)
    begin
      route_next = decode_route(sel_reg, single_mode);
      inter_next = single_mode && (sel_reg[1:0] == 2'h3);
    end
    calr_next   = ~cal_next[`BIT_CAL_RUN];
    divr_next   = ~cal_next[`BIT_CAL_RUN];
    pe_out_next = '{level: pe_reg[2:0], extra: pe_reg[`BIT_PE_EXTRA]};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pe_reg    <= `RST_LANE_PREEMPH_LEVEL;
      sel_reg   <= `RST_INPUT_SEL;
      cal_reg   <= `RST_CAL_EN;
      rdata_reg <= 8'h00;
      route_reg <= ROUTE_SOLO_A;
      inter_reg <= 1'b0;
      calr_reg  <= 1'b0;
      divr_reg  <= 1'b0;
      for (int i = 0; i < `NUM_LANES; i++)
        pe_out_reg[i] <= '0;
    end
    else
    begin
      pe_reg    <= pe_next;
      sel_reg   <= sel_next;
      cal_reg   <= cal_next;
      rdata_reg <= rdata_next;
      route_reg <= route_next;
      inter_reg <= inter_next;
      calr_reg  <= calr_next;
      divr_reg  <= divr_next;
      for (int i = 0; i < `NUM_LANES; i++)
        pe_out_reg[i] <= pe_out_next;
    end
  end

  assign rdata           = rdata_reg;
  assign lane_preemph    = pe_out_reg;
  assign input_route     = route_reg;
  assign solo_interleave = inter_reg;
  assign cal_reset       = calr_reg;
  assign div_reset       = divr_reg;

  // checks on the register-to-output relations
  property p_lane_level;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `OFS_LANE_PREEMPH_LEVEL) |=> ##1 (lane_preemph[15].level == $past(req.wdata[2:0], 2));
  endproperty
  a_lane_level: assert property (p_lane_level) else $error("lane level wrong");

  property p_lane_extra;
    @(posedge clk) disable iff (rst)
      ##2 (lane_preemph[0].extra == $past(pe_reg[3], 1));
  endproperty
  a_lane_extra: assert property (p_lane_extra) else $error("extra bit wrong");

  property p_swap;
    @(posedge clk) disable iff (rst)
      (cal_reg[0] && cal_done && !single_mode && sel_reg[4]) |=> input_route == ROUTE_B_A;
  endproperty
  a_swap: assert property (p_swap) else $error("swap not applied");

  property p_swap_ignored;
    @(posedge clk) disable iff (rst)
      (cal_reg[0] && cal_done && single_mode) |=> input_route != ROUTE_B_A;
  endproperty
  a_swap_ignored: assert property (p_swap_ignored) else $error("swap in solo");

  property p_solo_b;
    @(posedge clk) disable iff (rst)
      (cal_reg[0] && cal_done && single_mode && sel_reg[1:0] == 2'h2) |=> input_route == ROUTE_SOLO_B;
  endproperty
  a_solo_b: assert property (p_solo_b) else $error("solo b wrong");

  property p_hold_route;
    @(posedge clk) disable iff (rst)
      !(cal_reg[0] && cal_done) |=> $stable(input_route) && $stable(solo_interleave);
  endproperty
  a_hold_route: assert property (p_hold_route) else $error("route moved");

  property p_cal_hold;
    @(posedge clk) disable iff (rst)
      (req.wr && req.addr == `OFS_CAL_EN && !req.wdata[0]) |=> cal_reset ##1 1'b1;
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("cal not held");

  property p_div_reset;
    @(posedge clk) disable iff (rst)
      div_reset == cal_reset;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("dividers out of step");

  c_swap: cover property (@(posedge clk) disable iff (rst) input_route == ROUTE_B_A);
  c_inter: cover property (@(posedge clk) disable iff (rst) solo_interleave);
  c_hold: cover property (@(posedge clk) disable iff (rst) cal_reset ##1 !cal_reset);
endmodule : input_cal_ctrl

// file: common/input_cal_cfg.svh
// constants for the input, pre-emphasis and calibration control registers
// assumes an 8-bit register port addressed by the byte offsets below
`ifndef INPUT_CAL_CFG_SVH
`define INPUT_CAL_CFG_SVH
`define OFS_LANE_PREEMPH_LEVEL      8'h48
`define OFS_INPUT_SEL   8'h60
`define OFS_CAL_EN      8'h61
`define RST_LANE_PREEMPH_LEVEL      8'h00
`define RST_INPUT_SEL   8'h01
`define RST_CAL_EN      8'h01
`define MASK_LANE_PREEMPH_LEVEL     8'h0f
`define MASK_INPUT_SEL  8'h13
`define MASK_CAL_EN     8'h01
`define BIT_PE_EXTRA    3
`define BIT_SWAP        4
`define BIT_CAL_RUN     0
`define NUM_LANES       16
`endif

// file: common/input_cal_pkg.sv
// types for the input, pre-emphasis and calibration control block
// assumes nothing beyond the register port
package input_cal_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  typedef struct packed {
    logic [2:0] level;
    logic       extra;
  } preemph_t;
  // effective input routing towards the sampling front end
  typedef enum logic [1:0] {
    ROUTE_A_B    = 2'h0,
    ROUTE_B_A    = 2'h1,
    ROUTE_SOLO_A = 2'h3,
    ROUTE_SOLO_B = 2'h2
  } route_t;
  typedef enum logic [1:0] {
    CAL_HOLD = 2'h0,
    CAL_RUN  = 2'h1
  } cal_state_t;
endpackage : input_cal_pkg

// file: verif/input_cal_ctrl_bench.sv
// self-checking bench for the pre-emphasis, input mux and calibration enable registers
// assumes the package, the header and input_cal_ctrl are compiled before it
`timescale 1ns/1ns
`include "input_cal_cfg.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module input_cal_ctrl_bench;
  import input_cal_pkg::*;
  logic       clk;
  logic       rst;
  reg_req_t   req;
  logic [7:0] rdata;
  logic       single_mode;
  logic       cal_done;
  preemph_t   lane_preemph [`NUM_LANES];
  route_t     input_route;
  logic       solo_interleave;
  logic       cal_reset;
  logic       div_reset;
  int         errors;
  int         num_checks;
  // expected routing per single-mode pick code; the reserved code routes as input a
  route_t     pick_route [4] = '{ROUTE_SOLO_A, ROUTE_SOLO_A, ROUTE_SOLO_B, ROUTE_A_B};

  input_cal_ctrl uut (
    .clk             (clk),
    .rst             (rst),
    .req             (req),
    .rdata           (rdata),
    .single_mode     (single_mode),
    .cal_done        (cal_done),
    .lane_preemph    (lane_preemph),
    .input_route     (input_route),
    .solo_interleave (solo_interleave),
    .cal_reset       (cal_reset),
    .div_reset       (div_reset)
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one-cycle write strobe; released at the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    `CHK(rdata, exp)
  endtask : rd

  // one completed calibration, then let the routing register settle
  task automatic calib();
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : calib

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    rst = 1'b1;
    req = '0;
    single_mode = 1'b0;
    cal_done = 1'b0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_LANE_PREEMPH_LEVEL, 8'h00);
    rd(`OFS_INPUT_SEL, 8'h01);
    rd(`OFS_CAL_EN, 8'h01);
    rd(8'h50, 8'h00);
    `CHK(cal_reset, 1'b0)
    $display("test reset_values done");
    wr(`OFS_LANE_PREEMPH_LEVEL, 8'h0d);
    repeat (2) @(posedge clk);
    #1;
    for (int i = 0; i < `NUM_LANES; i++) `CHK(lane_preemph[i], 4'hb)
    rd(`OFS_LANE_PREEMPH_LEVEL, 8'h0d);
    wr(`OFS_LANE_PREEMPH_LEVEL, 8'h06);
    repeat (2) @(posedge clk);
    #1;
    `CHK(lane_preemph[15], 4'hc)
    $display("test preemphasis done");
    wr(`OFS_CAL_EN, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK({cal_reset, div_reset}, 2'b11)
    rd(`OFS_CAL_EN, 8'h00);
    // a finished calibration while held must not move the routing
    wr(`OFS_INPUT_SEL, 8'h10);
    calib();
    `CHK(input_route, ROUTE_SOLO_A)
    wr(`OFS_CAL_EN, 8'h01); // serial_link_on is never set here
    repeat (2) @(posedge clk);
    #1;
    `CHK({cal_reset, div_reset}, 2'b00)
    `CHK(input_route, ROUTE_SOLO_A)
    calib();
    `CHK(input_route, ROUTE_B_A)
    wr(`OFS_INPUT_SEL, 8'h00);
    calib();
    `CHK(input_route, ROUTE_A_B)
    $display("test calibration_and_swap done");
    @(posedge clk);
    single_mode <= 1'b1;
    // the reserved pick code is never written by software
    for (int c = 1; c < 4; c++)
    begin
      wr(`OFS_INPUT_SEL, 8'h10 | 8'(c));
      calib();
      `CHK(input_route, pick_route[c])
      `CHK(solo_interleave, 1'(c == 3))
    end
    wr(`OFS_INPUT_SEL, 8'h13);
    rd(`OFS_INPUT_SEL, 8'h13);
    $display("test single_mode done");
    print_verdict();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : input_cal_ctrl_bench
